// [mmu_mode_access_guard.sv]
// Address translation, memory partition, register filter and mode control
`timescale 1ns/1ps
`include "mmu_guard_cfg.svh"
module mmu_mode_access_guard #(
    parameter int SEGS        = 64,
    parameter int STACK_DEPTH = 4
) (
    input  wire logic                      mclk,        // Core clock
    input  wire logic                      rst,         // Sync reset
    input  wire mmu_guard_pkg::core_acc_t  core_acc,    // Core access
    output logic                           core_ready,  // Access taken
    output logic                           core_rvalid, // Read data valid
    output logic [7:0]                     core_rdata,  // Read data
    output mmu_guard_pkg::mem_req_t        mem_out,     // Memory request
    input  wire logic [7:0]                mem_rdata,   // Memory read data
    input  wire mmu_guard_pkg::sfr_req_t   sfr_req,     // Register access
    output logic                           sfr_rvalid,  // Register data ok
    output logic [7:0]                     sfr_rdata,   // Register data
    output mmu_guard_pkg::periph_req_t     periph_out,  // Filtered access
    input  wire logic [7:0]                periph_rdata,// Peripheral data
    output logic [15:0]                    grp_rights,  // Group rights
    input  wire logic                      system_vector_call_call,   // Vector call
    input  wire logic                      exc_take,    // Exception entry
    input  wire logic                      irq_take,    // Interrupt entry
    input  wire logic                      return_from_interrupt,        // Return
    input  wire logic                      irq_active,  // Irq in service
    input  wire logic                      user_irq_en, // User irqs on
    input  wire logic                      far_call,    // Long call
    input  wire logic [23:0]               far_addr,    // Its target
    input  wire logic                      test_avail,  // Test allowed
    input  wire logic                      go_test,     // Boot to test
    input  wire logic                      go_ctls,     // Boot to contactless
    output mmu_guard_pkg::mode_t           mode,        // Mode bits
    output mmu_guard_pkg::super_t          super_mode,  // Super kind
    output logic                           exc_raise,   // Exception pulse
    output mmu_guard_pkg::exc_cause_t      exc_cause,   // Its cause
    output logic                           walk_busy    // Table loading
);
    mmu_guard_pkg::mode_t       mode_q;
    mmu_guard_pkg::super_t      super_q;
    mmu_guard_pkg::walk_state_t wst_q;
    mmu_guard_pkg::seg_t        seg_q [SEGS];
    mmu_guard_pkg::seg_t        dbuf_q;
    mmu_guard_pkg::mem_req_t    mem_q;
    mmu_guard_pkg::periph_req_t per_q;
    mmu_guard_pkg::mode_t       stk_q [STACK_DEPTH];
    logic [SEGS-1:0]            seg_ok_q;
    logic [SEGS-1:0]            hit;
    logic [5:0]                 sidx_q;
    logic [3:0]                 bcnt_q;
    logic [23:0]                wptr_q;
    logic [23:0]                tbase_q;
    logic [15:0]                xsfr_q;
    logic [7:0]                 bank_q [3];
    logic [7:0]                 int_rd_q;
    logic [7:0]                 core_rd_q;
    logic [2:0]                 sp_q;
    logic                       irq_user_q;
    logic                       rsp_q;
    logic                       rsp_core_q;
    logic                       core_rv_q;
    logic                       sfr_p1_q;
    logic                       sfr_p2_q;
    logic                       src_per2_q;
    logic [7:0]                 int_rd2_q;
    logic                       sfr_rv_q;
    logic                       src_per_q;
    logic [7:0]                 sfr_rd_q;
    logic                       exc_q;
    mmu_guard_pkg::exc_cause_t  cause_q;

    logic        user;
    logic        test;
    logic [1:0]  bidx;
    logic        any_hit;
    logic [5:0]  hidx;
    logic [23:0] paddr;
    logic        perm_ok;
    logic        range_ok;
    logic        acc_go;
    logic        acc_bad;
    logic        is_sys;
    logic        sfr_ok;
    logic        system_vector_call_bad;
    logic        return_from_interrupt_ok;
    logic        tload;
    logic [1:0]  push_idx;

    assign user       = !mode_q.ssm && !mode_q.sm;
    assign test       = mode_q.ssm && super_q == mmu_guard_pkg::SUP_TEST;
    assign bidx       = mode_q.ssm ? 2'd2 : (mode_q.sm ? 2'd1 : 2'd0);
    assign mode       = mode_q;
    assign super_mode = super_q;
    assign walk_busy  = wst_q != mmu_guard_pkg::W_IDLE;
    assign core_ready = !walk_busy;
    assign mem_out    = mem_q;
    assign periph_out = per_q;
    assign core_rvalid = core_rv_q;
    assign core_rdata = core_rd_q;
    assign sfr_rvalid = sfr_rv_q;
    assign sfr_rdata  = sfr_rd_q;
    assign exc_raise  = exc_q;
    assign exc_cause  = cause_q;
    // Outside user mode every group is open
    assign grp_rights = user ? xsfr_q : 16'hFFFF;

    // One comparator pair per segment
    genvar g;
    generate
        for (g = 0; g < SEGS; g++) begin : g_hit
            assign hit[g] = seg_ok_q[g] && core_acc.vaddr >= seg_q[g].vstart
                            && core_acc.vaddr <= seg_q[g].vend;
        end
    endgenerate

    // Lowest numbered matching segment wins
    always_comb begin
        any_hit = 1'b0;
        hidx    = 6'd0;
        for (int i = SEGS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                any_hit = 1'b1;
                hidx    = 6'(i);
            end
        end
    end

    // Translate, then check rights and the fixed partition
    always_comb begin
        paddr   = core_acc.vaddr;
        perm_ok = 1'b1;
        if (user) begin
            paddr = core_acc.vaddr + seg_q[hidx].offset;
            case (core_acc.kind)
                mmu_guard_pkg::ACC_READ:
                    perm_ok = any_hit && seg_q[hidx].perm[`PERM_R];
                mmu_guard_pkg::ACC_WRITE:
                    perm_ok = any_hit && seg_q[hidx].perm[`PERM_W];
                mmu_guard_pkg::ACC_FETCH:
                    perm_ok = any_hit && seg_q[hidx].perm[`PERM_X];
                default: perm_ok = 1'b0;
            endcase
        end
        // Part sizes are constants, so no write can move them
        range_ok = (paddr >= `ROM_BASE && paddr - `ROM_BASE <
                    (test ? `ROM_SIZE : `ROM_PART))
                || (paddr >= `EE_BASE && paddr - `EE_BASE <
                    (test ? `EE_SIZE : `EE_PART))
                || (paddr >= `RAM_BASE && paddr - `RAM_BASE < `RAM_SIZE);
        acc_bad = core_acc.valid && core_ready && !(perm_ok && range_ok);
        acc_go  = core_acc.valid && core_ready && perm_ok && range_ok;
    end

    // Table walker: twelve bytes per descriptor, read one at a time
    always_ff @(posedge mclk) begin
        if (rst) begin
            wst_q    <= mmu_guard_pkg::W_IDLE;
            seg_ok_q <= '0;
            sidx_q   <= 6'd0;
            bcnt_q   <= 4'h0;
            wptr_q   <= `TBASE_RST;
            dbuf_q   <= '0;
        end else begin
            case (wst_q)
                mmu_guard_pkg::W_IDLE: begin
                    if (tload) begin
                        seg_ok_q <= '0;
                        sidx_q   <= 6'd0;
                        bcnt_q   <= 4'h0;
                        wptr_q   <= tbase_q;
                        wst_q    <= mmu_guard_pkg::W_READ;
                    end
                end
                mmu_guard_pkg::W_READ: wst_q <= mmu_guard_pkg::W_WAIT;
                mmu_guard_pkg::W_WAIT: begin
                    if (rsp_q && !rsp_core_q) begin
                        dbuf_q <= {dbuf_q[87:0], mem_rdata};
                        bcnt_q <= bcnt_q + 4'h1;
                        wst_q  <= (bcnt_q == `DESC_LAST) ?
                                  mmu_guard_pkg::W_NEXT :
                                  mmu_guard_pkg::W_READ;
                    end
                end
                mmu_guard_pkg::W_NEXT: begin
                    bcnt_q <= 4'h0;
                    if (dbuf_q.perm == `PERM_END) begin
                        wst_q <= mmu_guard_pkg::W_IDLE;
                    end else if (dbuf_q.perm == `PERM_CONT) begin
                        wptr_q <= dbuf_q.vstart;
                        wst_q  <= mmu_guard_pkg::W_READ;
                    end else begin
                        seg_ok_q[sidx_q] <= 1'b1;
                        sidx_q <= sidx_q + 6'd1;
                        wptr_q <= wptr_q + `DESC_BYTES;
                        wst_q  <= (sidx_q == 6'(SEGS - 1)) ?
                                  mmu_guard_pkg::W_IDLE :
                                  mmu_guard_pkg::W_READ;
                    end
                end
                default: wst_q <= mmu_guard_pkg::W_IDLE;
            endcase
        end
    end

    // Descriptor storage is written only by the walker
    always_ff @(posedge mclk) begin
        if (wst_q == mmu_guard_pkg::W_NEXT && dbuf_q.perm != `PERM_END
            && dbuf_q.perm != `PERM_CONT) begin
            seg_q[sidx_q] <= dbuf_q;
        end
    end

    // Memory port: walker reads take the port, core waits on ready
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_q      <= '0;
            rsp_q      <= 1'b0;
            rsp_core_q <= 1'b0;
        end else begin
            rsp_q      <= mem_q.req && !mem_q.we;
            // A walker read is always the one in flight during W_WAIT, so a
            // core read issued on the edge a load starts still returns
            rsp_core_q <= mem_q.req && !mem_q.we &&
                          wst_q != mmu_guard_pkg::W_WAIT;
            if (wst_q == mmu_guard_pkg::W_READ) begin
                mem_q <= '{req: 1'b1, we: 1'b0,
                           paddr: wptr_q + {20'h0, bcnt_q}, wdata: 8'h00};
            end else if (acc_go) begin
                mem_q <= '{req: 1'b1,
                           we: core_acc.kind == mmu_guard_pkg::ACC_WRITE,
                           paddr: paddr, wdata: core_acc.wdata};
            end else begin
                mem_q <= '0;
            end
        end
    end

    // Core read return; a refused access never issued a read
    always_ff @(posedge mclk) begin
        if (rst) begin
            core_rv_q <= 1'b0;
            core_rd_q <= 8'h00;
        end else begin
            core_rv_q <= rsp_q && rsp_core_q;
            if (rsp_q && rsp_core_q) begin
                core_rd_q <= mem_rdata;
            end
        end
    end

    // Group rights follow the segment of the latest user fetch
    always_ff @(posedge mclk) begin
        if (rst) begin
            xsfr_q <= 16'h0000;
        end else if (acc_go && user &&
                     core_acc.kind == mmu_guard_pkg::ACC_FETCH) begin
            xsfr_q <= seg_q[hidx].sfr;
        end
    end

    // Register filter decision
    always_comb begin
        is_sys = sfr_req.addr[`SFR_SYS_BIT];
        if (!is_sys) begin
            sfr_ok = grp_rights[sfr_req.addr[`SFR_GRP_HI:`SFR_GRP_LO]];
        end else begin
            // Fixed table; nothing in software can alter it
            case (sfr_req.addr)
                `SFR_MODE:   sfr_ok = 1'b1;
                `SFR_BANK:   sfr_ok = 1'b1;
                `SFR_IRQCFG, `SFR_TBASE0, `SFR_TBASE1, `SFR_TBASE2,
                `SFR_TLOAD:  sfr_ok = !user;
                default:     sfr_ok = 1'b0;
            endcase
        end
    end
    assign tload = sfr_req.valid && sfr_req.we && sfr_ok
                   && sfr_req.addr == `SFR_TLOAD;

    // Peripheral strobes only pass when permitted
    always_ff @(posedge mclk) begin
        if (rst) begin
            per_q <= '0;
        end else if (sfr_req.valid && !is_sys && sfr_ok) begin
            per_q <= '{re: !sfr_req.we, we: sfr_req.we,
                       addr: sfr_req.addr[6:0], wdata: sfr_req.wdata};
        end else begin
            per_q <= '0;
        end
    end

    // Local configuration registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_user_q <= `IRQCFG_RST;
            tbase_q    <= `TBASE_RST;
            bank_q[0]  <= `BANK_RST;
            bank_q[1]  <= `BANK_RST;
            bank_q[2]  <= `BANK_RST;
        end else if (sfr_req.valid && sfr_req.we && sfr_ok) begin
            case (sfr_req.addr)
                `SFR_IRQCFG: irq_user_q    <= sfr_req.wdata[0];
                `SFR_TBASE0: tbase_q[7:0]  <= sfr_req.wdata;
                `SFR_TBASE1: tbase_q[15:8] <= sfr_req.wdata;
                `SFR_TBASE2: tbase_q[23:16] <= sfr_req.wdata;
                `SFR_BANK:   bank_q[bidx]  <= sfr_req.wdata;
                default: ;
            endcase
        end
    end

    // Register reads answer three edges after the request; the extra stage
    // waits out the peripheral's one-cycle data latency
    always_ff @(posedge mclk) begin
        if (rst) begin
            sfr_p1_q   <= 1'b0;
            sfr_p2_q   <= 1'b0;
            src_per_q  <= 1'b0;
            src_per2_q <= 1'b0;
            int_rd_q   <= `SFR_BLOCKED;
            int_rd2_q  <= `SFR_BLOCKED;
            sfr_rv_q  <= 1'b0;
            sfr_rd_q  <= `SFR_BLOCKED;
        end else begin
            sfr_p1_q  <= sfr_req.valid && !sfr_req.we;
            src_per_q <= !is_sys && sfr_ok;
            int_rd_q  <= `SFR_BLOCKED;
            if (is_sys && sfr_ok) begin
                case (sfr_req.addr)
                    `SFR_MODE:   int_rd_q <= {6'h00, mode_q};
                    `SFR_IRQCFG: int_rd_q <= {7'h00, irq_user_q};
                    `SFR_TBASE0: int_rd_q <= tbase_q[7:0];
                    `SFR_TBASE1: int_rd_q <= tbase_q[15:8];
                    `SFR_TBASE2: int_rd_q <= tbase_q[23:16];
                    `SFR_BANK:   int_rd_q <= bank_q[bidx];
                    default:     int_rd_q <= `SFR_BLOCKED;
                endcase
            end
            sfr_p2_q   <= sfr_p1_q;
            src_per2_q <= src_per_q;
            int_rd2_q  <= int_rd_q;
            sfr_rv_q   <= sfr_p2_q;
            sfr_rd_q   <= src_per2_q ? periph_rdata : int_rd2_q;
        end
    end

    // Legality of the mode changing events
    assign system_vector_call_bad = system_vector_call_call && !user;
    assign return_from_interrupt_ok  = !user || (user_irq_en && irq_active);
    // A full stack keeps overwriting its top entry, never the bottom one
    assign push_idx = (sp_q == 3'(STACK_DEPTH)) ? 2'(STACK_DEPTH - 1)
                                               : sp_q[1:0];

    // Exception report: one pulse, registered
    always_ff @(posedge mclk) begin
        if (rst) begin
            exc_q   <= 1'b0;
            cause_q <= mmu_guard_pkg::EXC_NONE;
        end else begin
            exc_q   <= acc_bad || system_vector_call_bad || (return_from_interrupt && !return_from_interrupt_ok);
            if (acc_bad && !perm_ok) begin
                cause_q <= mmu_guard_pkg::EXC_PERM;
            end else if (acc_bad) begin
                cause_q <= mmu_guard_pkg::EXC_RANGE;
            end else if (system_vector_call_bad) begin
                cause_q <= mmu_guard_pkg::EXC_SYSTEM_VECTOR_CALL;
            end else if (return_from_interrupt && !return_from_interrupt_ok) begin
                cause_q <= mmu_guard_pkg::EXC_RETURN_FROM_INTERRUPT;
            end else begin
                cause_q <= mmu_guard_pkg::EXC_NONE;
            end
        end
    end

    // Privilege bits and the return stack; entries win over a clear write
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q <= `MODE_RST;
            sp_q   <= 3'd0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stk_q[i] <= '0;
            end
        end else if (exc_take || (irq_take && !irq_user_q) ||
                     (system_vector_call_call && user)) begin
            // Deeper nesting than the stack overwrites the top entry
            stk_q[push_idx] <= mode_q;
            if (sp_q < 3'(STACK_DEPTH)) begin
                sp_q <= sp_q + 3'd1;
            end
            mode_q.sm <= 1'b1;
        end else if (irq_take) begin
            stk_q[push_idx] <= mode_q;
            if (sp_q < 3'(STACK_DEPTH)) begin
                sp_q <= sp_q + 3'd1;
            end
        end else if (return_from_interrupt && return_from_interrupt_ok && sp_q != 3'd0) begin
            mode_q <= stk_q[sp_q[1:0] - 2'd1];
            sp_q   <= sp_q - 3'd1;
        end else if (far_call && far_addr == `USER_ENTRY &&
                     mode_q.sm && !mode_q.ssm) begin
            mode_q <= '0;
        end else if (sfr_req.valid && sfr_req.we && sfr_ok &&
                     sfr_req.addr == `SFR_MODE) begin
            mode_q <= mode_q & sfr_req.wdata[1:0];
        end
    end

    // Boot is left once and never re-entered short of reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            super_q <= mmu_guard_pkg::SUP_BOOT;
        end else if (super_q == mmu_guard_pkg::SUP_BOOT) begin
            if (go_test && test_avail && mode_q.ssm) begin
                super_q <= mmu_guard_pkg::SUP_TEST;
            end else if (go_ctls || !mode_q.ssm) begin
                super_q <= mmu_guard_pkg::SUP_CTLS;
            end
        end
    end
endmodule : mmu_mode_access_guard

// [mmu_guard_cfg.svh]
// Offsets, field positions, reset values and map constants of the guard
`ifndef MMU_GUARD_CFG_SVH
`define MMU_GUARD_CFG_SVH
`define ROM_BASE     24'h000000
`define ROM_SIZE     24'h010000
`define ROM_PART     24'h00C000
`define EE_BASE      24'h020000
`define EE_SIZE      24'h010000
`define EE_PART      24'h00C000
`define RAM_BASE     24'h040000
`define RAM_SIZE     24'h001000
`define USER_ENTRY   24'h800000
`define PERM_R       0
`define PERM_W       1
`define PERM_X       2
`define PERM_END     8'hFF
`define PERM_CONT    8'hFE
`define DESC_LAST    4'hB
`define DESC_BYTES   24'h00000C
`define SFR_SYS_BIT  7
`define SFR_GRP_HI   6
`define SFR_GRP_LO   3
`define SFR_MODE     8'h80
`define SFR_IRQCFG   8'h81
`define SFR_TBASE0   8'h82
`define SFR_TBASE1   8'h83
`define SFR_TBASE2   8'h84
`define SFR_TLOAD    8'h85
`define SFR_BANK     8'h86
`define SFR_BLOCKED  8'h00
`define MODE_RST     2'h2
`define IRQCFG_RST   1'b0
`define TBASE_RST    24'h000000
`define BANK_RST     8'h00
`endif

// [mmu_guard_pkg.sv]
// Types shared by the memory and register access guard
package mmu_guard_pkg;
    typedef enum logic [1:0] {
        ACC_READ  = 2'b00,
        ACC_WRITE = 2'b01,
        ACC_FETCH = 2'b10
    } acc_kind_t;
    typedef enum logic [1:0] {
        SUP_BOOT = 2'b00,
        SUP_TEST = 2'b01,
        SUP_CTLS = 2'b10
    } super_t;
    typedef enum logic [1:0] {
        W_IDLE = 2'b00,
        W_READ = 2'b01,
        W_WAIT = 2'b10,
        W_NEXT = 2'b11
    } walk_state_t;
    typedef enum logic [2:0] {
        EXC_NONE  = 3'b000,
        EXC_RANGE = 3'b001,
        EXC_PERM  = 3'b010,
        EXC_SYSTEM_VECTOR_CALL  = 3'b011,
        EXC_RETURN_FROM_INTERRUPT  = 3'b100
    } exc_cause_t;
    typedef struct packed {
        logic ssm;
        logic sm;
    } mode_t;
    typedef struct packed {
        logic        valid;
        acc_kind_t   kind;
        logic [23:0] vaddr;
        logic [7:0]  wdata;
    } core_acc_t;
    typedef struct packed {
        logic        req;
        logic        we;
        logic [23:0] paddr;
        logic [7:0]  wdata;
    } mem_req_t;
    typedef struct packed {
        logic [7:0]  perm;
        logic [23:0] vstart;
        logic [23:0] vend;
        logic [23:0] offset;
        logic [15:0] sfr;
    } seg_t;
    typedef struct packed {
        logic       valid;
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;
    typedef struct packed {
        logic       re;
        logic       we;
        logic [6:0] addr;
        logic [7:0] wdata;
    } periph_req_t;
endpackage : mmu_guard_pkg

// [mmu_guard_chk.sv]
// Port assertions of the access guard
`timescale 1ns/1ps
module mmu_guard_chk (
    input wire logic                      mclk,       // Clock
    input wire logic                      rst,        // Reset
    input wire mmu_guard_pkg::mem_req_t   mem_out,    // Memory req
    input wire mmu_guard_pkg::sfr_req_t   sfr_req,    // Reg access
    input wire logic                      sfr_rvalid, // Reg data ok
    input wire logic [7:0]                sfr_rdata,  // Reg data
    input wire logic [15:0]               grp_rights, // Group rights
    input wire logic                      system_vector_call_call,  // Vector call
    input wire logic                      exc_take,   // Exception
    input wire logic                      irq_take,   // Interrupt
    input wire logic                      return_from_interrupt,       // Return
    input wire logic                      far_call,   // Long call
    input wire logic [23:0]               far_addr,   // Its target
    input wire mmu_guard_pkg::mode_t      mode,       // Mode bits
    input wire logic                      exc_raise,  // Exc pulse
    input wire mmu_guard_pkg::exc_cause_t exc_cause   // Exc cause
);
    // No entry or return event this cycle; then bits may only stay or clear
    wire quiet = !(system_vector_call_call || exc_take || irq_take || return_from_interrupt);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_grp; mode != 2'b00 |-> grp_rights == 16'hFFFF; endproperty
    a_grp: assert property (p_grp) else $error("rights not full");
    property p_clr; quiet |=> (mode & ~$past(mode)) == 2'b00; endproperty
    a_clr: assert property (p_clr) else $error("mode bit set");
    property p_sve;
        system_vector_call_call && mode != 2'b00 |=> ##[0:1] exc_raise && exc_cause == 3'h3;
    endproperty
    a_sve: assert property (p_sve) else $error("no vector fault");
    property p_svu; system_vector_call_call && mode == 2'b00 |=> mode.sm; endproperty
    a_svu: assert property (p_svu) else $error("no system entry");
    property p_far;
        far_call && far_addr == 24'h800000 && mode == 2'b01 && quiet
        |=> mode == 2'b00;
    endproperty
    a_far: assert property (p_far) else $error("no user entry");
    property p_rng;
        mem_out.req |-> mem_out.paddr inside
        {[24'h0:24'hFFFF], [24'h20000:24'h2FFFF], [24'h40000:24'h40FFF]};
    endproperty
    a_rng: assert property (p_rng) else $error("req out of map");
    property p_nrq; exc_raise && exc_cause inside {3'h1, 3'h2} |-> !mem_out.req;
    endproperty
    a_nrq: assert property (p_nrq) else $error("refused but sent");
    property p_blk;
        sfr_req.valid && !sfr_req.we && mode == 2'b00
        && sfr_req.addr inside {[8'h81:8'h85]} |=> ##2 sfr_rvalid
        && sfr_rdata == 8'h00;
    endproperty
    a_blk: assert property (p_blk) else $error("blocked read leaks");
endmodule : mmu_guard_chk
bind mmu_mode_access_guard mmu_guard_chk chk_u (.mclk, .rst, .mem_out,
    .sfr_req, .sfr_rvalid, .sfr_rdata, .grp_rights, .system_vector_call_call, .exc_take,
    .irq_take, .return_from_interrupt, .far_call, .far_addr, .mode, .exc_raise, .exc_cause);

// [mem_partner.sv]
// Memory and peripheral data source facing the guard
`timescale 1ns/1ps
module mem_partner (
    input  wire logic                       mclk,        // Clock
    input  wire mmu_guard_pkg::mem_req_t    mem_out,     // Memory req
    input  wire mmu_guard_pkg::periph_req_t periph_out,  // Periph req
    output logic [7:0]                      mem_rdata,   // Memory data
    output logic [7:0]                      periph_rdata // Periph data
);
    initial {mem_rdata, periph_rdata} = 16'h0000;
    // Answer one cycle after the strobe; else flip so stale data is wrong
    always @(posedge mclk) begin
        mem_rdata <= mem_out.req ? mem_out.paddr[7:0] ^ 8'h5A : ~mem_rdata;
        periph_rdata <= periph_out.re ? {1'b0, periph_out.addr}
                                      : ~periph_rdata;
    end
endmodule : mem_partner

// [mmu_mode_access_guard_test.sv]
// Self-checking bench of the access guard
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module mmu_mode_access_guard_test;
    logic mclk = 1'b0, rst = 1'b1, core_ready, core_rvalid, sfr_rvalid;
    logic exc_raise, walk_busy;
    logic [7:0] core_rdata, mem_rdata, sfr_rdata, periph_rdata, rb, rdc, sdc;
    logic [15:0] grp_rights;
    logic [23:0] far_addr, pac;
    logic [6:0] pl;
    logic [2:0] lv, ecc;
    mmu_guard_pkg::core_acc_t core_acc;
    mmu_guard_pkg::mem_req_t mem_out;
    mmu_guard_pkg::sfr_req_t sfr_req;
    mmu_guard_pkg::periph_req_t periph_out;
    mmu_guard_pkg::mode_t mode;
    mmu_guard_pkg::super_t super_mode;
    mmu_guard_pkg::exc_cause_t exc_cause;
    int errors = 0, total_checks = 0, cyc = 0, nreq = 0, n, em = 2, q[$];
    mmu_mode_access_guard dut_u (.mclk, .rst, .core_acc, .core_ready,
        .core_rvalid, .core_rdata, .mem_out, .mem_rdata, .sfr_req,
        .sfr_rvalid, .sfr_rdata, .periph_out, .periph_rdata, .grp_rights,
        .system_vector_call_call(pl[0]), .exc_take(pl[1]), .irq_take(pl[2]), .return_from_interrupt(pl[3]),
        .irq_active(lv[0]), .user_irq_en(lv[1]), .far_call(pl[4]),
        .far_addr, .test_avail(lv[2]), .go_test(pl[5]), .go_ctls(pl[6]),
        .mode, .super_mode, .exc_raise, .exc_cause, .walk_busy);
    mem_partner p_u (.mclk, .mem_out, .periph_out, .mem_rdata, .periph_rdata);
    initial forever #5 mclk = ~mclk;
    // Catch one-cycle answers as they pass; a hang ends the run
    always @(posedge mclk) begin
        cyc++;
        if (core_rvalid) rdc <= core_rdata;
        if (sfr_rvalid) sdc <= sfr_rdata;
        if (exc_raise) ecc <= exc_cause;
        if (mem_out.req) pac <= mem_out.paddr;
        if (mem_out.req) nreq++;
        if (cyc > 3000) begin errors++; finish_test(); end
    end
    task acc(input logic [23:0] a);
        @(negedge mclk) core_acc = '{1'b1, mmu_guard_pkg::ACC_READ, a, 8'h00};
        @(negedge mclk) core_acc.valid = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : acc
    task sf(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk) sfr_req = '{1'b1, w, a, d};
        @(negedge mclk) sfr_req.valid = 1'b0;
        repeat (3) @(negedge mclk);
        if (w && a == 8'h80) em &= d;
    endtask : sf
    task ev(input int i);
        @(negedge mclk) pl[i] = 1'b1;
        @(negedge mclk) pl = 7'h00;
        repeat (3) @(negedge mclk);
    endtask : ev
    task finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        {core_acc, sfr_req, pl, lv, ecc} = '0;
        far_addr = 24'h800000;
        rb = $urandom(32'hE635);
        rb = $urandom;
        repeat (3) @(negedge mclk) rst = 1'b1;
        rst = 1'b0;
        `CHK("mode", 2'h2, mode)
        `CHK("rights", 16'hFFFF, grp_rights)
        acc({16'h0001, rb});
        `CHK("paddr", {16'h0001, rb}, pac)
        `CHK("rdata", rb ^ 8'h5A, rdc)
        acc(24'h00C000);
        `CHK("cause", 3'h1, ecc)
        lv[2] = 1'b1;
        ev(5);
        `CHK("super", mmu_guard_pkg::SUP_TEST, super_mode)
        n = nreq;
        acc(24'h00C000);
        `CHK("reqs", n + 1, nreq)
        sf(1'b1, 8'h80, 8'h01);
        `CHK("mode", em[1:0], mode)
        sf(1'b1, 8'h80, 8'h03);
        `CHK("mode", em[1:0], mode)
        ev(0);
        em |= 1;
        `CHK("mode", em[1:0], mode)
        ev(0);
        `CHK("cause", 3'h3, ecc)
        ev(4);
        em = 0;
        `CHK("mode", em[1:0], mode)
        acc(24'h000100);
        `CHK("cause", 3'h2, ecc)
        sdc = 8'hFF;
        sf(1'b0, 8'h81, 8'h00);
        `CHK("blocked", 8'h00, sdc)
        ev(0);
        q.push_back(em);
        em |= 1;
        `CHK("mode", em[1:0], mode)
        ev(3);
        em = q.pop_back();
        `CHK("mode", em[1:0], mode)
        ev(3);
        `CHK("cause", 3'h4, ecc)
        ev(1);
        em |= 1;
        `CHK("mode", em[1:0], mode)
        sf(1'b0, 8'h18, 8'h00);
        `CHK("periph", 8'h18, sdc)
        sf(1'b1, 8'h86, rb);
        sf(1'b0, 8'h86, 8'h00);
        `CHK("bank", rb, sdc)
        n = nreq;
        sf(1'b1, 8'h82, 8'hA5);
        sf(1'b1, 8'h85, 8'h00);
        `CHK("busy", 1'b1, walk_busy)
        repeat (60) @(negedge mclk);
        `CHK("walk", n + 12, nreq)
        `CHK("tbyte", 24'h0000B0, pac)
        `CHK("ready", 1'b1, core_ready)
        finish_test();
    end
endmodule : mmu_mode_access_guard_test
